// ===== verilog/irq_flag_pkg.sv
// Shared constants and types for the interrupt request flag block.
package irq_flag_pkg;

  // Vector handling.
  localparam logic [15:0] DEFAULT_VECTOR     = 16'h00a0;
  localparam logic [15:0] DEFAULT_ENTRY_ADDR = 16'h80a0;
  localparam int          VECTOR_W           = 16;

  // Request source indices.
  localparam int SRC_EXT_ZERO  = 0;
  localparam int SRC_CONV_DONE = 1;
  localparam int SRC_SERIAL_RX = 2;
  localparam int SRC_COUNT     = 3;

  // Controller register offsets on APB.
  localparam logic [7:0] OFF_MODE    = 8'h00;
  localparam logic [7:0] OFF_ENABLE  = 8'h04;
  localparam logic [7:0] OFF_FLAGS   = 8'h08;
  localparam logic [7:0] OFF_CLEAR   = 8'h0c;
  localparam logic [7:0] OFF_ACCEPT  = 8'h10;
  localparam logic [7:0] OFF_VECTOR  = 8'h14;
  localparam logic [7:0] OFF_CONVRD  = 8'h18;
  localparam logic [7:0] OFF_RXRD    = 8'h1c;

  // Field positions.
  localparam int MODE_LEVEL_BIT = 0;
  localparam int VEC_DEFAULT_BIT = 16;

  // Per-source vector values; arbitrary neutral figures.
  localparam logic [15:0] VEC_EXT_ZERO  = 16'h0028;
  localparam logic [15:0] VEC_CONV_DONE = 16'h0070;
  localparam logic [15:0] VEC_SERIAL_RX = 16'h0058;

  typedef enum logic [1:0] {
    CMD_NONE,
    CMD_CLEAR_EXT,
    CMD_ACCEPT
  } cpu_cmd_type;

  typedef enum {
    ST_IDLE,
    ST_FETCH,
    ST_DONE
  } ack_state_type;

endpackage

// ===== verilog/irq_flag_if.sv
// Interface joining the request flag block and its CPU-side controller.
interface irq_flag_if;
  logic        level_mode;     // Ext zero input mode, 1 = level.
  logic        level_mode_we;  // Write strobe for level_mode.
  logic        enable_write;   // Strobe: write of the enable register.
  logic        enable_value;   // Ext zero enable value written.
  logic        flag_clear;     // Strobe: instruction clears ext zero flag.
  logic        conv_read;      // Strobe: conversion result register read.
  logic        rx_read;        // Strobe: receive buffer read.
  logic        accept;         // Strobe: CPU starts vector fetch.
  logic [2:0]  pending;        // Request flags seen by the CPU.
  logic        fetch_busy;     // Vector fetch in progress.
  logic        vector_valid;   // Vector ready, one cycle.
  logic [15:0] vector;         // Vector value.
  logic [15:0] entry_addr;     // Service start address.

  modport device (
    input  level_mode, level_mode_we, enable_write, enable_value, flag_clear,
           conv_read, rx_read, accept,
    output pending, fetch_busy, vector_valid, vector, entry_addr
  );
  modport cpu (
    output level_mode, level_mode_we, enable_write, enable_value, flag_clear,
           conv_read, rx_read, accept,
    input  pending, fetch_busy, vector_valid, vector, entry_addr
  );
endinterface

// ===== verilog/irq_request_flag_control.sv
// Request flags, ext zero edge and level modes and vector fetch for the device end.

module irq_request_flag_control #(
  parameter int FETCH_CYCLES = 2
) (
  input  wire logic   pclk,
  input  wire logic   presetn,
  input  wire logic   ext_irq_zero,
  input  wire logic   converter_done_irq,
  input  wire logic   serial_rx_irq,
  irq_flag_if.device  bus
);

  // The fetch counter is eight bits wide, so longer fetches cannot be counted.
  if (FETCH_CYCLES < 1 || FETCH_CYCLES > 255) begin : g_fetch_check
    $error("FETCH_CYCLES out of range");
  end

  localparam logic [7:0] FETCH_LAST = 8'(FETCH_CYCLES - 1);

  logic                                sync1_reg;
  logic                                sync2_reg;
  logic                                sync3_reg;
  logic                                pin_level_reg;
  logic                                level_mode_reg;
  logic                                ext_latch_reg;
  logic                                conv_latch_reg;
  logic                                rx_latch_reg;
  logic                                clear_seen_reg;
  logic [7:0]                          fetch_cnt_reg;
  logic [irq_flag_pkg::SRC_COUNT-1:0]  snap_reg;
  logic [irq_flag_pkg::SRC_COUNT-1:0]  pending_reg;
  logic                                vector_valid_reg;
  logic                                busy_reg;
  logic [15:0]                         vector_reg;
  logic [15:0]                         entry_reg;
  logic                                ext_pending;
  logic                                pin_rise;
  logic                                pin_fall;
  logic                                to_level;
  logic                                accept_ext;
  irq_flag_pkg::ack_state_type         state_reg;

  // Pin synchroniser; the filtered level changes only when stages two and three agree.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg     <= 1'b0;
      sync2_reg     <= 1'b0;
      sync3_reg     <= 1'b0;
      pin_level_reg <= 1'b0;
    end else begin
      sync1_reg <= ext_irq_zero;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      if (sync2_reg == sync3_reg) begin
        pin_level_reg <= sync3_reg;
      end
    end
  end

  assign pin_rise = (sync2_reg == sync3_reg) && sync3_reg && !pin_level_reg;
  assign pin_fall = (sync2_reg == sync3_reg) && !sync3_reg && pin_level_reg;
  assign to_level = bus.level_mode_we && bus.level_mode && !level_mode_reg;

  // Mode register as last written by the controller.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_mode_reg <= 1'b0;
    end else if (bus.level_mode_we) begin
      level_mode_reg <= bus.level_mode;
    end
  end

  // In level mode the pending indication is the pin itself, no stored event.
  assign ext_pending = level_mode_reg ? pin_level_reg : ext_latch_reg;

  assign accept_ext = (state_reg == irq_flag_pkg::ST_IDLE) && bus.accept &&
                      ext_pending && !level_mode_reg;

  // Edge latch: a rising edge sets it and wins over any clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_latch_reg <= 1'b0;
    end else if (level_mode_reg && !(bus.level_mode_we && !bus.level_mode)) begin
      ext_latch_reg <= 1'b0;
    end else if (level_mode_reg) begin
      // Leaving level mode keeps a request that the pin still holds.
      ext_latch_reg <= (pin_level_reg && !pin_fall) || pin_rise;
    end else if (pin_rise && !level_mode_reg) begin
      ext_latch_reg <= 1'b1;
    end else if (to_level) begin
      ext_latch_reg <= 1'b0;
    end else if (bus.flag_clear || accept_ext) begin
      ext_latch_reg <= 1'b0;
    end else if (bus.enable_write && !bus.enable_value) begin
      ext_latch_reg <= 1'b0;
    end
  end

  // Converter and receive latches ignore instruction writes; only reads clear them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_latch_reg <= 1'b0;
      rx_latch_reg   <= 1'b0;
    end else begin
      if (converter_done_irq) begin
        conv_latch_reg <= 1'b1;
      end else if (bus.conv_read) begin
        conv_latch_reg <= 1'b0;
      end
      if (serial_rx_irq) begin
        rx_latch_reg <= 1'b1;
      end else if (bus.rx_read) begin
        rx_latch_reg <= 1'b0;
      end
    end
  end

  // Events that count as a flag clear, except an enable write of zero; a falling pin in level mode counts too.
  logic clear_event;
  assign clear_event = bus.flag_clear || bus.conv_read || bus.rx_read || to_level ||
                       (level_mode_reg && pin_fall);

  // Vector fetch sequencer; a clear landing in the fetch forces the default vector.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg        <= irq_flag_pkg::ST_IDLE;
      fetch_cnt_reg    <= 8'h00;
      clear_seen_reg   <= 1'b0;
      snap_reg         <= '0;
      vector_valid_reg <= 1'b0;
      vector_reg       <= 16'h0000;
      entry_reg        <= 16'h0000;
      busy_reg         <= 1'b0;
    end else begin
      vector_valid_reg <= 1'b0;
      case (state_reg)
        irq_flag_pkg::ST_IDLE: begin
          clear_seen_reg <= 1'b0;
          fetch_cnt_reg  <= 8'h00;
          if (bus.accept) begin
            snap_reg  <= {rx_latch_reg, conv_latch_reg, ext_pending};
            busy_reg  <= 1'b1;
            state_reg <= irq_flag_pkg::ST_FETCH;
          end
        end
        irq_flag_pkg::ST_FETCH: begin
          if (clear_event) begin
            clear_seen_reg <= 1'b1;
          end
          if (fetch_cnt_reg == FETCH_LAST) begin
            state_reg <= irq_flag_pkg::ST_DONE;
          end else begin
            fetch_cnt_reg <= fetch_cnt_reg + 8'h01;
          end
        end
        irq_flag_pkg::ST_DONE: begin
          vector_valid_reg <= 1'b1;
          busy_reg         <= 1'b0;
          state_reg        <= irq_flag_pkg::ST_IDLE;
          if (clear_seen_reg || clear_event || snap_reg == '0) begin
            vector_reg <= irq_flag_pkg::DEFAULT_VECTOR;
            entry_reg  <= irq_flag_pkg::DEFAULT_ENTRY_ADDR;
          end else if (snap_reg[irq_flag_pkg::SRC_EXT_ZERO]) begin
            vector_reg <= irq_flag_pkg::VEC_EXT_ZERO;
            entry_reg  <= irq_flag_pkg::DEFAULT_ENTRY_ADDR - irq_flag_pkg::DEFAULT_VECTOR
                          + irq_flag_pkg::VEC_EXT_ZERO;
          end else if (snap_reg[irq_flag_pkg::SRC_CONV_DONE]) begin
            vector_reg <= irq_flag_pkg::VEC_CONV_DONE;
            entry_reg  <= irq_flag_pkg::DEFAULT_ENTRY_ADDR - irq_flag_pkg::DEFAULT_VECTOR
                          + irq_flag_pkg::VEC_CONV_DONE;
          end else begin
            vector_reg <= irq_flag_pkg::VEC_SERIAL_RX;
            entry_reg  <= irq_flag_pkg::DEFAULT_ENTRY_ADDR - irq_flag_pkg::DEFAULT_VECTOR
                          + irq_flag_pkg::VEC_SERIAL_RX;
          end
        end
        default: begin
          state_reg <= irq_flag_pkg::ST_IDLE;
          busy_reg  <= 1'b0;
        end
      endcase
    end
  end

  // Registered pending view toward the CPU.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending_reg <= '0;
    end else begin
      pending_reg <= {rx_latch_reg, conv_latch_reg, ext_pending};
    end
  end

  assign bus.pending      = pending_reg;
  assign bus.fetch_busy   = busy_reg;  // Registered copy of state not idle.
  assign bus.vector_valid = vector_valid_reg;
  assign bus.vector       = vector_reg;
  assign bus.entry_addr   = entry_reg;

endmodule

// ===== verilog/irq_cpu_controller.sv
// CPU-side controller: APB registers that drive the request flag block.
module irq_cpu_controller (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  irq_flag_if.cpu          bus
);

  logic        level_reg;
  logic        level_we_reg;
  logic        enable_reg;
  logic        enable_we_reg;
  logic        clear_reg;
  logic        conv_rd_reg;
  logic        rx_rd_reg;
  logic        accept_reg;
  logic [16:0] vec_reg;
  logic        access;
  logic        wr;
  logic        rd;

  assign access = psel && penable;
  assign wr     = access && pwrite;
  assign rd     = access && !pwrite;

  // Command strobes last one cycle; software is expected to disable first.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_reg     <= 1'b0;
      level_we_reg  <= 1'b0;
      enable_reg    <= 1'b0;
      enable_we_reg <= 1'b0;
      clear_reg     <= 1'b0;
      conv_rd_reg   <= 1'b0;
      rx_rd_reg     <= 1'b0;
      accept_reg    <= 1'b0;
    end else begin
      level_we_reg  <= 1'b0;
      enable_we_reg <= 1'b0;
      clear_reg     <= 1'b0;
      conv_rd_reg   <= 1'b0;
      rx_rd_reg     <= 1'b0;
      accept_reg    <= 1'b0;
      if (wr && paddr == irq_flag_pkg::OFF_MODE) begin
        level_reg    <= pwdata[irq_flag_pkg::MODE_LEVEL_BIT];
        level_we_reg <= 1'b1;
      end else if (wr && paddr == irq_flag_pkg::OFF_ENABLE) begin
        enable_reg    <= pwdata[0];
        enable_we_reg <= 1'b1;
      end else if (wr && paddr == irq_flag_pkg::OFF_CLEAR) begin
        clear_reg <= 1'b1;
      end else if (wr && paddr == irq_flag_pkg::OFF_ACCEPT) begin
        accept_reg <= !bus.fetch_busy;
      end else if (rd && paddr == irq_flag_pkg::OFF_CONVRD) begin
        conv_rd_reg <= 1'b1;
      end else if (rd && paddr == irq_flag_pkg::OFF_RXRD) begin
        rx_rd_reg <= 1'b1;
      end
    end
  end

  // Vector capture for software; bit 16 marks the default vector.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vec_reg <= 17'h00000;
    end else if (bus.vector_valid) begin
      vec_reg <= {bus.vector == irq_flag_pkg::DEFAULT_VECTOR, bus.vector};
    end
  end

  // APB answer: zero wait states, unmapped addresses give pslverr.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      if (psel && !penable) begin
        if (paddr == irq_flag_pkg::OFF_MODE) begin
          prdata <= {31'h0, level_reg};
        end else if (paddr == irq_flag_pkg::OFF_ENABLE) begin
          prdata <= {31'h0, enable_reg};
        end else if (paddr == irq_flag_pkg::OFF_FLAGS) begin
          prdata <= {28'h0, bus.fetch_busy, bus.pending};
        end else if (paddr == irq_flag_pkg::OFF_VECTOR) begin
          prdata <= {15'h0, vec_reg};
        end else if (paddr == irq_flag_pkg::OFF_CLEAR || paddr == irq_flag_pkg::OFF_ACCEPT ||
                     paddr == irq_flag_pkg::OFF_CONVRD || paddr == irq_flag_pkg::OFF_RXRD) begin
          prdata <= 32'h00000000;
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  assign bus.level_mode    = level_reg;
  assign bus.level_mode_we = level_we_reg;
  assign bus.enable_write  = enable_we_reg;
  assign bus.enable_value  = enable_reg;
  assign bus.flag_clear    = clear_reg;
  assign bus.conv_read     = conv_rd_reg;
  assign bus.rx_read       = rx_rd_reg;
  assign bus.accept        = accept_reg;

endmodule

// ===== test/irq_flag_props.sv
// Checker for the signals between the request flag block and its controller.
module irq_flag_props #(
  parameter int FETCH_CYCLES = 2
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        level_mode,
  input wire logic        level_mode_we,
  input wire logic        enable_write,
  input wire logic        flag_clear,
  input wire logic        conv_read,
  input wire logic        rx_read,
  input wire logic        accept,
  input wire logic [2:0]  pending,
  input wire logic        fetch_busy,
  input wire logic        vector_valid,
  input wire logic [15:0] vector,
  input wire logic [15:0] entry_addr
);
  logic [3:0] hist_reg;
  logic [3:0] busy_cnt_reg;
  logic       clr_seen_reg;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Recent events allowed to lower the ext zero flag; a pin cannot do it in edge mode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hist_reg <= 4'h0;
    else hist_reg <= {hist_reg[2:0], flag_clear | enable_write | accept | level_mode_we};
  end

  // Length of the current vector fetch, so a long count needs no repetition.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) busy_cnt_reg <= 4'h0;
    else busy_cnt_reg <= fetch_busy ? busy_cnt_reg + 4'h1 : 4'h0;
  end

  // Remembers a flag clear that hit a fetch until the next accept.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) clr_seen_reg <= 1'b0;
    else if (accept) clr_seen_reg <= 1'b0;
    else if (flag_clear && fetch_busy) clr_seen_reg <= 1'b1;
  end

  property p_conv_clear;
    $fell(pending[1]) |-> $past(conv_read) || $past(conv_read, 2);
  endproperty
  a_conv_clear: assert property (p_conv_clear) else $error("converter flag fell without read");
  property p_rx_clear;
    $fell(pending[2]) |-> $past(rx_read) || $past(rx_read, 2);
  endproperty
  a_rx_clear: assert property (p_rx_clear) else $error("receive flag fell without read");
  property p_edge_hold;
    !level_mode && !$past(level_mode) && $fell(pending[0]) |-> hist_reg != 4'h0;
  endproperty
  a_edge_hold: assert property (p_edge_hold) else $error("edge flag fell on its own");
  property p_busy_len;
    $fell(fetch_busy) |-> busy_cnt_reg == 4'(FETCH_CYCLES + 1);
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("fetch length wrong");
  property p_accept_valid;
    accept && !fetch_busy |-> ##[1:8] vector_valid;
  endproperty
  a_accept_valid: assert property (p_accept_valid) else $error("no vector after accept");
  property p_valid_pulse;
    vector_valid |=> !vector_valid;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("vector valid too long");
  property p_clr_default;
    vector_valid && clr_seen_reg |-> vector == irq_flag_pkg::DEFAULT_VECTOR;
  endproperty
  a_clr_default: assert property (p_clr_default) else $error("no default vector");
  property p_entry;
    vector_valid && vector == irq_flag_pkg::DEFAULT_VECTOR
      |-> entry_addr == irq_flag_pkg::DEFAULT_ENTRY_ADDR;
  endproperty
  a_entry: assert property (p_entry) else $error("default entry wrong");

  c_fetch_clear: cover property (vector_valid && clr_seen_reg);
  c_conv_clear: cover property ($fell(pending[1]));
  c_level_set: cover property (level_mode && pending[0]);
endmodule

// ===== test/testbench.sv
// Self-checking bench joining both ends of the request flag interface.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0, presetn = 1'b0, pin = 1'b0, conv_irq = 1'b0, rx_irq = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pslverr, pready, re;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rq;
  int          num_errors = 0, total_checks = 0, cyc = 0;

  irq_flag_if bus_if();
  irq_request_flag_control #(.FETCH_CYCLES(2)) i_irq_request_flag_control (.pclk(pclk),
    .presetn(presetn), .ext_irq_zero(pin), .converter_done_irq(conv_irq),
    .serial_rx_irq(rx_irq), .bus(bus_if));
  irq_cpu_controller i_irq_cpu_controller (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bus(bus_if));
  irq_flag_props #(.FETCH_CYCLES(2)) i_irq_flag_props (.pclk(pclk), .presetn(presetn),
    .level_mode(bus_if.level_mode), .level_mode_we(bus_if.level_mode_we),
    .enable_write(bus_if.enable_write), .flag_clear(bus_if.flag_clear),
    .conv_read(bus_if.conv_read), .rx_read(bus_if.rx_read), .accept(bus_if.accept),
    .pending(bus_if.pending), .fetch_busy(bus_if.fetch_busy),
    .vector_valid(bus_if.vector_valid), .vector(bus_if.vector),
    .entry_addr(bus_if.entry_addr));

  // Free-running bus clock.
  always #25 pclk = ~pclk;

  // Cuts a hung run short; the whole sequence needs well under this.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One transfer; psel stays up so a second transfer may follow at once.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Wait states end only with pready; the cycle ceiling catches a hang.
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rq = prdata;
    re = pslverr;
    penable <= 1'b0;
  endtask

  // A strobe lands one edge after the access and the pending view two edges later.
  task automatic idle();
    psel <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    idle();
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                    input string nm);
    apb(1'b0, a, 32'h0);
    idle();
    chk(nm, e, rq & m);
  endtask

  // The pin goes through a synchroniser, so each change is given time to land.
  task automatic set_pin(input logic v);
    pin <= v;
    repeat (6 + $urandom % 4) @(posedge pclk);
  endtask

  initial begin
    void'($urandom(32'h3ff4));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(irq_flag_pkg::OFF_FLAGS, 32'hf, 32'h0, "flags after reset");
    apb(1'b1, 8'h20, $urandom);
    idle();
    chk("unmapped error", 32'h1, {31'h0, re});
    // Converter and receive flags ignore writes and clear only on their reads.
    for (int s = 1; s < 3; s++) begin
      conv_irq <= (s == 1);
      rx_irq <= (s == 2);
      @(posedge pclk);
      conv_irq <= 1'b0;
      rx_irq <= 1'b0;
      @(posedge pclk);
      wr(irq_flag_pkg::OFF_FLAGS, $urandom);
      wr(irq_flag_pkg::OFF_CLEAR, 32'hffffffff);
      rd(irq_flag_pkg::OFF_FLAGS, 32'h6, 32'h1 << s, "flag kept");
      rd(s == 1 ? irq_flag_pkg::OFF_CONVRD : irq_flag_pkg::OFF_RXRD, 32'hffffffff, 32'h0,
         "result");
      rd(irq_flag_pkg::OFF_FLAGS, 32'h6, 32'h0, "flag read clear");
    end
    set_pin(1'b1);
    set_pin(1'b0);
    rd(irq_flag_pkg::OFF_FLAGS, 32'h1, 32'h1, "edge latched");
    wr(irq_flag_pkg::OFF_CLEAR, 32'h1);
    rd(irq_flag_pkg::OFF_FLAGS, 32'h1, 32'h0, "edge cleared");
    set_pin(1'b1);
    set_pin(1'b0);
    wr(irq_flag_pkg::OFF_MODE, 32'h1);
    rd(irq_flag_pkg::OFF_FLAGS, 32'h1, 32'h0, "edge to level");
    set_pin(1'b1);
    rd(irq_flag_pkg::OFF_FLAGS, 32'h1, 32'h1, "level high");
    // The pin stays high through the whole response, so the ext zero vector is served.
    wr(irq_flag_pkg::OFF_ACCEPT, 32'h1);
    repeat (8) @(posedge pclk);
    rd(irq_flag_pkg::OFF_VECTOR, 32'h1ffff, {16'h0, irq_flag_pkg::VEC_EXT_ZERO},
       "level vector");
    set_pin(1'b0);
    rd(irq_flag_pkg::OFF_FLAGS, 32'h1, 32'h0, "level low");
    set_pin(1'b1);
    wr(irq_flag_pkg::OFF_MODE, 32'h0);
    set_pin(1'b0);
    rd(irq_flag_pkg::OFF_FLAGS, 32'h1, 32'h1, "level to edge kept");
    wr(irq_flag_pkg::OFF_ENABLE, 32'h0);
    rd(irq_flag_pkg::OFF_FLAGS, 32'h1, 32'h0, "level to edge");
    // A clear landing in the middle of the fetch forces the default vector.
    set_pin(1'b1);
    set_pin(1'b0);
    apb(1'b1, irq_flag_pkg::OFF_ACCEPT, 32'h1);
    apb(1'b1, irq_flag_pkg::OFF_CLEAR, 32'h1);
    idle();
    repeat (8) @(posedge pclk);
    rd(irq_flag_pkg::OFF_VECTOR, 32'h1ffff, {15'h0, 1'b1, irq_flag_pkg::DEFAULT_VECTOR},
       "default vector");
    conv_irq <= 1'b1;
    @(posedge pclk);
    conv_irq <= 1'b0;
    wr(irq_flag_pkg::OFF_ACCEPT, 32'h1);
    repeat (8) @(posedge pclk);
    rd(irq_flag_pkg::OFF_VECTOR, 32'h1ffff, {16'h0, irq_flag_pkg::VEC_CONV_DONE},
       "plain vector");
    end_of_test();
  end
endmodule
